// file: src/alarm_mask_and_timing_adjust_regs.v
// alarm mask, per-lane fifo alarm vector and sampling-instant trim registers behind apb
//
// Behaviour
// RULE1: six mask bits 5..0 each keep one alarm source out of the summary alarm.
// RULE2: mask resets to 0x3F, all sources masked; bits 7:6 reserved.
// RULE3: sixteen-bit lane vector, bit i set on lane i fifo overflow or underflow.
// RULE4: writing one clears a lane bit, zero leaves it; persistent condition sets it again.
// RULE5: writing one to the lane-fifo status bit clears the whole lane vector.
// RULE6: lane vector resets to 0xFFFF.
// RULE7: each eight-bit trim register drives one core's sampling-instant adjustment by mode.
// RULE8: trims default to factory values, readable and overwritable by software.
// RULE9: trim at 0x310 applies to core A in dual-channel mode.
// RULE10: trim at 0x313 applies to core B in dual-channel mode.
// RULE11: trim at 0x314 applies to core A, single mode, foreground cal, input A.
// RULE12: summary alarm is one while any unmasked status bit is set.
// RULE13: lane-fifo status bit sets on any active lane event, cleared by writing one.
// RULE14: an event in the same cycle as a clearing write wins; the bit stays set.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "alarm_trim_consts.vh"
module alarm_mask_and_timing_adjust_regs (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire [`LANES-1:0] lane_fifo_overflow,
  input wire [`LANES-1:0] lane_fifo_underflow,
  input wire [`LANES-1:0] lane_active,
  input wire pll_unlocked,
  input wire link_not_in_data,
  input wire clocks_realigned,
  input wire oscillator_phase_upset,
  input wire divider_mismatch,
  input wire dual_channel_mode,
  input wire foreground_cal_en,
  input wire sampling_analog_input_a,
  input wire [`TRIM_W-1:0] factory_trim_a_dual,
  input wire [`TRIM_W-1:0] factory_trim_b_dual,
  input wire [`TRIM_W-1:0] factory_trim_a_single_ina,
  output reg [`TRIM_W-1:0] core_a_trim_applied,
  output reg [`TRIM_W-1:0] core_b_trim_applied,
  output reg summary_alarm,
  output wire irq
);
  localparam SYNC_W = 3 * `LANES + 5;

  // alarm and lane pins arrive from the link and analog domains, so they pass the synchroniser; mode and factory trim pins do not
  wire [SYNC_W-1:0] sync_in;
  wire [SYNC_W-1:0] sync_out;
  assign sync_in = {lane_fifo_overflow, lane_fifo_underflow, lane_active, pll_unlocked,
    link_not_in_data, clocks_realigned, oscillator_phase_upset, divider_mismatch};

  sync3 #(
    .W(SYNC_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d(sync_in),
    .q(sync_out)
  );

  wire [`LANES-1:0] ovf_s;
  wire [`LANES-1:0] unf_s;
  wire [`LANES-1:0] active_s;
  wire [4:0] other_src_s;
  assign ovf_s = sync_out[SYNC_W-1:2*`LANES+5];
  assign unf_s = sync_out[2*`LANES+4:`LANES+5];
  assign active_s = sync_out[`LANES+4:5];
  assign other_src_s = sync_out[4:0];

  // registers
  reg [`SRC_W-1:0] alarm_source_mask_q;
  reg [`SRC_W-1:0] alarm_status_register_q;
  reg [`LANES-1:0] lane_fifo_alarm_vector_q;
  reg [`TRIM_W-1:0] core_a_dual_timing_trim_q;
  reg [`TRIM_W-1:0] core_b_dual_timing_trim_q;
  reg [`TRIM_W-1:0] core_a_single_ina_timing_trim_q;
  reg [`IRQ_W-1:0] irq_status_q;
  reg [`IRQ_W-1:0] irq_enable_q;
  reg trim_loaded_q;
  reg summary_prev_q;

  // apb decode
  wire setup_phase;
  wire access_phase;
  wire wr_en;
  wire [`REG_IDX_W-1:0] idx;
  wire word_aligned;
  reg mapped;

  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign idx = paddr[`ADDR_W-1:2];
  assign word_aligned = (paddr[1:0] == 2'h0);
  // zero wait states: every access finishes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = access_phase & ~mapped;
  assign wr_en = access_phase & pwrite & mapped & ce;

  always @* begin
    mapped = word_aligned;
    case (idx)
      `IDX_SUMMARY_ALARM: mapped = word_aligned & ~pwrite;
      `IDX_ALARM_STATUS: mapped = word_aligned;
      `IDX_ALARM_MASK: mapped = word_aligned;
      `IDX_LANE_VECTOR: mapped = word_aligned;
      `IDX_TRIM_A_DUAL: mapped = word_aligned;
      `IDX_TRIM_B_DUAL: mapped = word_aligned;
      `IDX_TRIM_A_SINGLE_INA: mapped = word_aligned;
      `IDX_IRQ_STATUS: mapped = word_aligned & ~pwrite;
      `IDX_IRQ_CLEAR: mapped = word_aligned & pwrite;
      `IDX_IRQ_ENABLE: mapped = word_aligned;
      default: mapped = 1'b0;
    endcase
  end

  // byte strobes gate the lanes of a write
  wire [31:0] wmask;
  wire [31:0] wdata_m;
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wdata_m = pwdata & wmask;

  wire wr_status;
  wire wr_mask;
  wire wr_lane;
  wire wr_trim_a;
  wire wr_trim_b;
  wire wr_trim_ai;
  wire wr_irq_clr;
  wire wr_irq_en;
  assign wr_status = wr_en & (idx == `IDX_ALARM_STATUS);
  assign wr_mask = wr_en & (idx == `IDX_ALARM_MASK);
  assign wr_lane = wr_en & (idx == `IDX_LANE_VECTOR);
  assign wr_trim_a = wr_en & (idx == `IDX_TRIM_A_DUAL);
  assign wr_trim_b = wr_en & (idx == `IDX_TRIM_B_DUAL);
  assign wr_trim_ai = wr_en & (idx == `IDX_TRIM_A_SINGLE_INA);
  assign wr_irq_clr = wr_en & (idx == `IDX_IRQ_CLEAR);
  assign wr_irq_en = wr_en & (idx == `IDX_IRQ_ENABLE);

  // alarm events
  wire [`LANES-1:0] lane_event;
  wire any_active_lane_event;
  wire [`SRC_W-1:0] status_set;
  wire [`SRC_W-1:0] status_clr;
  wire [`LANES-1:0] lane_clr;
  wire summary_d;

  assign lane_event = ovf_s | unf_s; // see RULE3
  assign any_active_lane_event = |(lane_event & active_s); // see RULE13
  assign status_set = {any_active_lane_event, other_src_s};
  assign status_clr = wr_status ? wdata_m[`SRC_W-1:0] : {`SRC_W{1'b0}};
  // a one on the lane-fifo status bit wipes the whole lane vector as well
  assign lane_clr = (wr_lane ? wdata_m[`LANES-1:0] : {`LANES{1'b0}}) |
    {`LANES{status_clr[`BIT_LANE_FIFO]}}; // see RULE4 see RULE5
  assign summary_d = |(alarm_status_register_q & ~alarm_source_mask_q); // see RULE1 see RULE12

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_source_mask_q <= `RST_ALARM_MASK; // see RULE2
      alarm_status_register_q <= `RST_ALARM_STATUS;
      lane_fifo_alarm_vector_q <= `RST_LANE_VECTOR; // see RULE6
      summary_alarm <= 1'b0;
      summary_prev_q <= 1'b0;
    end else if (ce) begin
      if (wr_mask) begin
        alarm_source_mask_q <= wdata_m[`SRC_W-1:0]; // see RULE1
      end
      // set beats clear when both land in one cycle
      alarm_status_register_q <= (alarm_status_register_q & ~status_clr) | status_set; // see RULE13 see RULE14
      lane_fifo_alarm_vector_q <= (lane_fifo_alarm_vector_q & ~lane_clr) | lane_event; // see RULE4 see RULE14
      summary_alarm <= summary_d; // see RULE12
      summary_prev_q <= summary_alarm;
    end
  end

  // trims: reset takes a constant, the factory values are copied in on the first enabled edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_loaded_q <= 1'b0;
      core_a_dual_timing_trim_q <= `RST_TRIM;
      core_b_dual_timing_trim_q <= `RST_TRIM;
      core_a_single_ina_timing_trim_q <= `RST_TRIM;
    end else if (ce) begin
      if (!trim_loaded_q) begin
        trim_loaded_q <= 1'b1;
        core_a_dual_timing_trim_q <= factory_trim_a_dual; // see RULE8
        core_b_dual_timing_trim_q <= factory_trim_b_dual; // see RULE8
        core_a_single_ina_timing_trim_q <= factory_trim_a_single_ina; // see RULE8
      end else begin
        if (wr_trim_a) begin
          core_a_dual_timing_trim_q <= wdata_m[`TRIM_W-1:0]; // see RULE8
        end
        if (wr_trim_b) begin
          core_b_dual_timing_trim_q <= wdata_m[`TRIM_W-1:0]; // see RULE8
        end
        if (wr_trim_ai) begin
          core_a_single_ina_timing_trim_q <= wdata_m[`TRIM_W-1:0]; // see RULE8
        end
      end
    end
  end

  // trim selection per core and mode; modes outside this bank fall back to the dual trims
  wire single_ina_sel;
  assign single_ina_sel = ~dual_channel_mode & foreground_cal_en & sampling_analog_input_a;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_a_trim_applied <= `RST_TRIM;
      core_b_trim_applied <= `RST_TRIM;
    end else if (ce) begin
      if (single_ina_sel) begin
        core_a_trim_applied <= core_a_single_ina_timing_trim_q; // see RULE7 see RULE11
      end else begin
        core_a_trim_applied <= core_a_dual_timing_trim_q; // see RULE7 see RULE9
      end
      core_b_trim_applied <= core_b_dual_timing_trim_q; // see RULE7 see RULE10
    end
  end

  // interrupts: lane event and summary alarm rising edge, sticky, set wins over clear
  wire [`IRQ_W-1:0] irq_set;
  wire [`IRQ_W-1:0] irq_clr;
  assign irq_set = {summary_alarm & ~summary_prev_q, |lane_event};
  assign irq_clr = wr_irq_clr ? wdata_m[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
  assign irq = |(irq_status_q & irq_enable_q);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= `RST_IRQ;
      irq_enable_q <= `RST_IRQ;
    end else if (ce) begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
      if (wr_irq_en) begin
        irq_enable_q <= wdata_m[`IRQ_W-1:0];
      end
    end
  end

  // read data is captured in the setup cycle and shown in the access cycle
  reg [31:0] rdata_d;
  always @* begin
    rdata_d = 32'h0000_0000;
    case (idx)
      `IDX_SUMMARY_ALARM: rdata_d = {31'h0, summary_alarm};
      `IDX_ALARM_STATUS: rdata_d = {26'h0, alarm_status_register_q};
      `IDX_ALARM_MASK: rdata_d = {26'h0, alarm_source_mask_q};
      `IDX_LANE_VECTOR: rdata_d = {16'h0, lane_fifo_alarm_vector_q};
      `IDX_TRIM_A_DUAL: rdata_d = {24'h0, core_a_dual_timing_trim_q};
      `IDX_TRIM_B_DUAL: rdata_d = {24'h0, core_b_dual_timing_trim_q};
      `IDX_TRIM_A_SINGLE_INA: rdata_d = {24'h0, core_a_single_ina_timing_trim_q};
      `IDX_IRQ_STATUS: rdata_d = {30'h0, irq_status_q};
      `IDX_IRQ_ENABLE: rdata_d = {30'h0, irq_enable_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      if (setup_phase && !pwrite && word_aligned) begin
        prdata <= rdata_d;
      end else if (setup_phase) begin
        prdata <= 32'h0000_0000;
      end
    end
  end
endmodule

// file: src/alarm_trim_consts.vh
// offsets, field positions, reset values and widths of the alarm and timing trim registers
`ifndef ALARM_TRIM_CONSTS_VH
`define ALARM_TRIM_CONSTS_VH

`define ADDR_W 12
`define REG_IDX_W 10

`define IDX_SUMMARY_ALARM 10'h2C0
`define IDX_ALARM_STATUS 10'h2C1
`define IDX_ALARM_MASK 10'h2C2
`define IDX_LANE_VECTOR 10'h2C4
`define IDX_TRIM_A_DUAL 10'h310
`define IDX_TRIM_B_DUAL 10'h313
`define IDX_TRIM_A_SINGLE_INA 10'h314
`define IDX_IRQ_STATUS 10'h320
`define IDX_IRQ_CLEAR 10'h321
`define IDX_IRQ_ENABLE 10'h322

`define SRC_W 6
`define BIT_LANE_FIFO 5
`define BIT_PLL 4
`define BIT_LINK 3
`define BIT_REALIGN 2
`define BIT_OSC_PHASE 1
`define BIT_DIVIDER 0

`define LANES 16
`define TRIM_W 8
`define IRQ_W 2
`define IRQ_BIT_LANE 0
`define IRQ_BIT_SUMMARY 1

`define RST_ALARM_MASK 6'h3F
`define RST_ALARM_STATUS 6'h3F
`define RST_LANE_VECTOR 16'hFFFF
`define RST_TRIM 8'h00
`define RST_IRQ 2'h0

`endif

// file: src/sync3.v
// three-stage input synchroniser that passes a change once stages two and three agree
`timescale 1ns/1ps
module sync3 #(
  parameter W = 1
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  integer i;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end else if (ce) begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // per bit, so one noisy bit does not hold back the others
      for (i = 0; i < W; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// file: tb/alarm_regs_properties.sv
// concurrent checks on the alarm and trim register block ports
`timescale 1ns/1ps
`include "alarm_trim_consts.vh"
module alarm_regs_chk (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire [`LANES-1:0] lane_fifo_overflow,
  input wire [`LANES-1:0] lane_active,
  input wire pll_unlocked,
  input wire dual_channel_mode,
  input wire foreground_cal_en,
  input wire sampling_analog_input_a,
  input wire [`TRIM_W-1:0] core_a_trim_applied,
  input wire [`TRIM_W-1:0] core_b_trim_applied,
  input wire summary_alarm
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // only byte-0 writes matter: every field here sits in the low byte or two
  wire wr = psel && penable && pwrite && ce && pstrb[0];
  wire rd = psel && penable && !pwrite;
  a_mask_all_gates: assert property (
    wr && paddr == 12'hB08 && pwdata[5:0] == 6'h3F |-> ##2 !summary_alarm)
    else $error("summary alarm high with every source masked");
  a_mask_reserved_zero: assert property (
    rd && paddr == 12'hB08 |-> prdata[31:6] == 26'h0)
    else $error("reserved mask bits read nonzero");
  a_lane_bit_set: assert property (
    lane_fifo_overflow[3] [*8] ##0 (rd && paddr == 12'hB10) |-> prdata[3])
    else $error("lane alarm bit missing after held overflow");
  a_status_fifo_set: assert property (
    (lane_fifo_overflow[3] && lane_active[3]) [*8] ##0 (rd && paddr == 12'hB04) |-> prdata[5])
    else $error("lane fifo status bit missing");
  a_summary_unmasked: assert property (
    pll_unlocked [*8] ##0 (wr && paddr == 12'hB08 && !pwdata[4]) |-> ##2 summary_alarm)
    else $error("summary alarm low with unmasked source set");
  a_trim_a_dual: assert property (
    wr && paddr == 12'hC40 ##0 dual_channel_mode [*3] |-> core_a_trim_applied == $past(pwdata[7:0], 2))
    else $error("core a dual trim not applied");
  a_trim_b_dual: assert property (
    wr && paddr == 12'hC4C |-> ##2 core_b_trim_applied == $past(pwdata[7:0], 2))
    else $error("core b trim not applied");
  a_trim_a_single: assert property (
    wr && paddr == 12'hC50 ##0 (!dual_channel_mode && foreground_cal_en && sampling_analog_input_a) [*3]
    |-> core_a_trim_applied == $past(pwdata[7:0], 2))
    else $error("core a single trim not applied");
endmodule
bind alarm_mask_and_timing_adjust_regs alarm_regs_chk chk_u (.pclk, .presetn, .ce, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .lane_fifo_overflow, .lane_active, .pll_unlocked,
  .dual_channel_mode, .foreground_cal_en, .sampling_analog_input_a, .core_a_trim_applied,
  .core_b_trim_applied, .summary_alarm);

// file: tb/tb_top.sv
// self-checking bench for the alarm mask, lane alarm vector and trim registers
`timescale 1ns/1ps
module tb_top;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [15:0] ovf = 16'h0;
  reg [15:0] unf = 16'h0;
  reg [15:0] act = 16'hFF7F;
  reg [4:0] src = 5'h0;
  reg dual = 1'b1;
  reg fg = 1'b0;
  reg analog_input_a = 1'b0;
  reg [31:0] rv;
  reg er;
  integer n_fail = 0;
  integer compares = 0;
  integer i;
  wire pready;
  wire pslverr;
  wire irq;
  wire sum;
  wire [31:0] prdata;
  wire [7:0] ta;
  wire [7:0] tbv;
  always #20 pclk = ~pclk;
  // factory fuse values are arbitrary test patterns
  alarm_mask_and_timing_adjust_regs dut_u (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb(4'hF), .pready, .prdata, .pslverr, .lane_fifo_overflow(ovf),
    .lane_fifo_underflow(unf), .lane_active(act), .pll_unlocked(src[4]),
    .link_not_in_data(src[3]), .clocks_realigned(src[2]), .oscillator_phase_upset(src[1]),
    .divider_mismatch(src[0]), .dual_channel_mode(dual), .foreground_cal_en(fg),
    .sampling_analog_input_a(analog_input_a), .factory_trim_a_dual(8'h11), .factory_trim_b_dual(8'h22),
    .factory_trim_a_single_ina(8'h33), .core_a_trim_applied(ta), .core_b_trim_applied(tbv),
    .summary_alarm(sum), .irq);
  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // one apb transfer; ends with an idle edge so the next setup never lands in the same step
  task bus(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      // line up on a rising edge, since a caller may have stopped at a falling edge to look
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge pclk);
      end
      if (n == 20) begin
        n_fail = n_fail + 1;
        end_sim;
      end
      rv = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task t_reset;
    begin
      bus(0, 12'hB08, 0); chk(rv, 32'h3F);
      bus(0, 12'hB10, 0); chk(rv, 32'hFFFF);
      bus(0, 12'hC40, 0); chk(rv, 32'h11);
      bus(0, 12'hC4C, 0); chk(rv, 32'h22);
      bus(0, 12'hC50, 0); chk(rv, 32'h33);
      chk(ta, 8'h11);
      chk(tbv, 8'h22);
      bus(0, 12'hB0C, 0); chk(er, 1'b1);
      $display("test reset done");
    end
  endtask
  task t_lane;
    begin
      bus(1, 12'hB10, 32'h1); bus(0, 12'hB10, 0); chk(rv, 32'hFFFE);
      bus(1, 12'hB04, 32'h20); bus(0, 12'hB10, 0); chk(rv, 32'h0);
      ovf <= 16'h0008;
      repeat (8) @(posedge pclk);
      bus(0, 12'hB10, 0); chk(rv, 32'h8);
      bus(0, 12'hB04, 0); chk(rv & 32'h20, 32'h20);
      bus(1, 12'hB10, 32'h8); bus(0, 12'hB10, 0); chk(rv, 32'h8);
      ovf <= 16'h0;
      repeat (8) @(posedge pclk);
      bus(1, 12'hB04, 32'h20); bus(0, 12'hB10, 0); chk(rv, 32'h0);
      unf <= 16'h0080;
      repeat (8) @(posedge pclk);
      bus(0, 12'hB10, 0); chk(rv, 32'h80);
      bus(0, 12'hB04, 0); chk(rv & 32'h20, 32'h0);
      unf <= 16'h0;
      repeat (8) @(posedge pclk);
      bus(1, 12'hB10, 32'h80); bus(0, 12'hB10, 0); chk(rv, 32'h0);
      $display("test lane done");
    end
  endtask
  task t_alarm;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        bus(1, 12'hB04, 32'h3F);
        src[i] <= 1'b1;
        repeat (8) @(posedge pclk);
        bus(0, 12'hB04, 0); chk(rv, 32'h1 << i);
        bus(1, 12'hB08, 32'h3F & ~(32'h1 << i));
        // summary flop updates on the edge bus returns on, so look half a cycle later
        @(negedge pclk);
        chk(sum, 1'b1);
        bus(1, 12'hB08, 32'h3F);
        @(negedge pclk);
        chk(sum, 1'b0);
        @(posedge pclk);
        src[i] <= 1'b0;
        repeat (8) @(posedge pclk);
      end
      bus(1, 12'hB08, 32'hFF); bus(0, 12'hB08, 0); chk(rv, 32'h3F);
      $display("test alarm done");
    end
  endtask
  task t_trim;
    begin
      bus(1, 12'hC40, 32'h5A); bus(0, 12'hC40, 0); chk(rv, 32'h5A);
      chk(ta, 8'h5A);
      bus(1, 12'hC4C, 32'hA5);
      @(negedge pclk);
      chk(tbv, 8'hA5);
      @(posedge pclk);
      dual <= 1'b0;
      fg <= 1'b1;
      analog_input_a <= 1'b1;
      repeat (2) @(posedge pclk);
      bus(1, 12'hC50, 32'h3C);
      @(negedge pclk);
      chk(ta, 8'h3C);
      @(posedge pclk);
      analog_input_a <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(ta, 8'h5A);
      dual <= 1'b1;
      $display("test trim done");
    end
  endtask
  task t_irq;
    begin
      bus(1, 12'hC84, 32'h3); bus(1, 12'hC88, 32'h1); chk(irq, 1'b0);
      ovf <= 16'h0002;
      repeat (8) @(posedge pclk);
      ovf <= 16'h0;
      repeat (8) @(posedge pclk);
      chk(irq, 1'b1);
      bus(0, 12'hC80, 0); chk(rv & 32'h1, 32'h1);
      bus(1, 12'hC88, 32'h0); chk(irq, 1'b0);
      bus(1, 12'hC88, 32'h1); chk(irq, 1'b1);
      bus(1, 12'hC84, 32'h1); chk(irq, 1'b0);
      $display("test irq done");
    end
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    t_reset;
    t_lane;
    t_alarm;
    t_trim;
    t_irq;
    end_sim;
  end
endmodule
